// >>> hdl/nsl_pkg.sv
// constants, state and pattern types for the node-state LED sequencer
// assumes a single 250 MHz core clock shared by every user of this package
// What this block does
// - green LED stays off while the interface is inactive.
// - managing node, inactive, no frame before timeout: go to preop one.
// - managing node seeing another node's frames before timeout never starts.
// - controlled node, inactive, no frame before timeout: go plain ethernet.
// - controlled node, inactive, frame seen before timeout: go to preop one.
// - green LED flickers near 10 Hz in plain ethernet state.
// - plain ethernet state runs the port as ordinary TCP/IP, no cyclic traffic.
// - managing node leaves plain ethernet only through an interface reset.
// - controlled node in plain ethernet goes to preop one on protocol frames.
// - preop one shows a single green flash once per second.
// - managing node in preop one runs reduced cycle, no cyclic traffic.
// - controlled node in preop one takes configuration, start-of-cycle moves to preop two.
// - controlled node lights red in preop one when the managing node failed.
package nsl_pkg;

  typedef enum logic [1:0] {
    inactive_state,
    plain_ethernet_state,
    preop_one_state,
    preop_two_state
  } nsl_state_e;

  typedef enum logic [1:0] {
    led_off,
    led_flicker,
    led_flash
  } nsl_led_e;

  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned CYC_PER_MS       = CLK_MHZ * 1000;
  // flicker near 10 Hz: 50 ms on, 50 ms off
  localparam int unsigned FLICKER_HALF_MS  = 50;
  // single flash: 200 ms on within a 1000 ms period
  localparam int unsigned FLASH_ON_MS      = 200;
  localparam int unsigned FLASH_PERIOD_MS  = 1000;
  localparam int unsigned FLICKER_HALF_CYC = FLICKER_HALF_MS * CYC_PER_MS;
  localparam int unsigned FLASH_ON_CYC     = FLASH_ON_MS * CYC_PER_MS;
  localparam int unsigned FLASH_PERIOD_CYC = FLASH_PERIOD_MS * CYC_PER_MS;

  localparam int unsigned PRESCALE_W       = 28;
  localparam int unsigned TIMEOUT_W        = 32;

endpackage : nsl_pkg

// >>> hdl/nsl_led_pattern.sv
// prescaled pattern generator for the green status LED
// assumes mode_i changes only together with a restart_i pulse
`timescale 1ns/1ps
module nsl_led_pattern #(
  parameter int unsigned FLICKER_HALF_CYC = nsl_pkg::FLICKER_HALF_CYC,
  parameter int unsigned FLASH_ON_CYC     = nsl_pkg::FLASH_ON_CYC,
  parameter int unsigned FLASH_PERIOD_CYC = nsl_pkg::FLASH_PERIOD_CYC
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             clk_en_i,
  input  wire logic             restart_i,
  input  wire nsl_pkg::nsl_led_e mode_i,
  output logic                  led_o
);

  localparam logic [nsl_pkg::PRESCALE_W-1:0] HALF_LAST =
    nsl_pkg::PRESCALE_W'(FLICKER_HALF_CYC - 1);
  localparam logic [nsl_pkg::PRESCALE_W-1:0] ON_CNT =
    nsl_pkg::PRESCALE_W'(FLASH_ON_CYC);
  localparam logic [nsl_pkg::PRESCALE_W-1:0] PERIOD_LAST =
    nsl_pkg::PRESCALE_W'(FLASH_PERIOD_CYC - 1);

  logic [nsl_pkg::PRESCALE_W-1:0] cnt_q;
  logic [nsl_pkg::PRESCALE_W-1:0] cnt_d;
  logic                           flick_q;
  logic                           flick_d;
  logic                           led_d;
  wire                            cnt_wrap;

  assign cnt_wrap = (mode_i == nsl_pkg::led_flicker) ? (cnt_q == HALF_LAST)
                                                     : (cnt_q == PERIOD_LAST);
  // phase restarts on every state change so a pattern always opens cleanly
  assign cnt_d   = (restart_i || cnt_wrap) ? '0 : cnt_q + 1'b1;
  assign flick_d = restart_i ? 1'b1 : (cnt_wrap ? ~flick_q : flick_q);
  assign led_d   = (mode_i == nsl_pkg::led_flicker) ? flick_d :
                   (mode_i == nsl_pkg::led_flash)   ? (cnt_d < ON_CNT) :
                   1'b0;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q   <= '0;
      flick_q <= 1'b0;
      led_o   <= 1'b0;
    end else if (clk_en_i) begin
      cnt_q   <= cnt_d;
      flick_q <= flick_d;
      led_o   <= led_d;
    end
  end

  chk_flicker_toggles: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
    clk_en_i && !restart_i && mode_i == nsl_pkg::led_flicker && cnt_wrap
    |=> led_o == !$past(flick_q))
    else $error("flicker did not toggle at prescaler wrap");

endmodule : nsl_led_pattern

// >>> hdl/nsl_node_state.sv
// node-state sequencer with dual status LED for a real-time ethernet port
// assumes frame detection happens upstream and arrives as one-cycle pulses
`timescale 1ns/1ps
module nsl_node_state #(
  parameter int unsigned FLICKER_HALF_CYC = nsl_pkg::FLICKER_HALF_CYC,
  parameter int unsigned FLASH_ON_CYC     = nsl_pkg::FLASH_ON_CYC,
  parameter int unsigned FLASH_PERIOD_CYC = nsl_pkg::FLASH_PERIOD_CYC
) (
  input  wire logic                           core_clk_i,
  input  wire logic                           reset_n_i,
  input  wire logic                           clk_en_i,
  input  wire logic                           iface_reset_i,
  input  wire logic                           managing_node_i,
  input  wire logic [nsl_pkg::TIMEOUT_W-1:0]  timeout_cycles_i,
  input  wire logic                           proto_frame_i,
  input  wire logic                           soc_frame_i,
  input  wire logic                           mn_failed_i,
  output logic [1:0]                          state_o,
  output logic                                led_green_o,
  output logic                                led_red_o,
  output logic                                mn_halted_o,
  output logic                                tcp_ip_mode_o,
  output logic                                reduced_cycle_o,
  output logic                                accept_config_o,
  output logic                                cyclic_enable_o
);

  nsl_pkg::nsl_state_e             state_q;
  nsl_pkg::nsl_state_e             state_d;
  logic [nsl_pkg::TIMEOUT_W-1:0]   tmo_cnt_q;
  logic [nsl_pkg::TIMEOUT_W-1:0]   tmo_cnt_d;
  logic                            halted_q;
  logic                            halted_d;
  logic                            red_q;
  logic                            red_d;
  logic                            tcp_q;
  logic                            reduced_q;
  logic                            accept_q;
  logic                            cyclic_q;
  nsl_pkg::nsl_led_e               led_mode;
  wire                             is_mn;
  wire                             is_cn;
  wire                             in_inactive;
  wire                             in_plain;
  wire                             in_preop1;
  wire                             in_preop2;
  wire                             tmo_expired;
  wire                             watching;
  wire                             state_change;

  assign is_mn       = managing_node_i;
  assign is_cn       = !managing_node_i;
  assign in_inactive = (state_q == nsl_pkg::inactive_state);
  assign in_plain    = (state_q == nsl_pkg::plain_ethernet_state);
  assign in_preop1   = (state_q == nsl_pkg::preop_one_state);
  assign in_preop2   = (state_q == nsl_pkg::preop_two_state);

  // the window stays open only while inactive and not yet halted
  assign watching    = in_inactive && !halted_q;
  assign tmo_expired = (tmo_cnt_q >= timeout_cycles_i);

  // counter stops once expired so a long stay cannot wrap it round
  assign tmo_cnt_d = iface_reset_i ? '0 :
                     (watching && !tmo_expired) ? tmo_cnt_q + 1'b1 :
                     tmo_cnt_q;

  // a frame seen in the same cycle as expiry wins: it arrived in time
  always_comb begin
    state_d  = state_q;
    halted_d = halted_q;
    if (iface_reset_i) begin
      state_d  = nsl_pkg::inactive_state;
      halted_d = 1'b0;
    end else begin
      unique case (state_q)
        nsl_pkg::inactive_state: begin
          if (watching && is_mn) begin
            if (proto_frame_i) begin
              halted_d = 1'b1;
            end else if (tmo_expired) begin
              state_d = nsl_pkg::preop_one_state;
            end
          end else if (watching && is_cn) begin
            if (proto_frame_i) begin
              state_d = nsl_pkg::preop_one_state;
            end else if (tmo_expired) begin
              state_d = nsl_pkg::plain_ethernet_state;
            end
          end
        end
        nsl_pkg::plain_ethernet_state: begin
          // managing node holds here until the interface is reset
          if (is_cn && proto_frame_i) begin
            state_d = nsl_pkg::preop_one_state;
          end
        end
        nsl_pkg::preop_one_state: begin
          if (is_cn && soc_frame_i) begin
            state_d = nsl_pkg::preop_two_state;
          end
        end
        nsl_pkg::preop_two_state: begin
          state_d = nsl_pkg::preop_two_state;
        end
      endcase
    end
  end

  assign state_change = (state_d != state_q);

  // mode follows the next state so the pattern opens on the edge that restarts it
  assign led_mode = (state_d == nsl_pkg::plain_ethernet_state) ? nsl_pkg::led_flicker :
                    (state_d == nsl_pkg::preop_one_state ||
                     state_d == nsl_pkg::preop_two_state) ? nsl_pkg::led_flash :
                    nsl_pkg::led_off;

  // red only meaningful to a controlled node waiting on its manager
  assign red_d = is_cn && (state_d == nsl_pkg::preop_one_state) && mn_failed_i;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q   <= nsl_pkg::inactive_state;
      tmo_cnt_q <= '0;
      halted_q  <= 1'b0;
      red_q     <= 1'b0;
    end else if (clk_en_i) begin
      state_q   <= state_d;
      tmo_cnt_q <= tmo_cnt_d;
      halted_q  <= halted_d;
      red_q     <= red_d;
    end
  end

  // mode flags registered from the next state so they line up with state_o
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tcp_q     <= 1'b0;
      reduced_q <= 1'b0;
      accept_q  <= 1'b0;
      cyclic_q  <= 1'b0;
    end else if (clk_en_i) begin
      tcp_q     <= (state_d == nsl_pkg::plain_ethernet_state);
      reduced_q <= is_mn && (state_d == nsl_pkg::preop_one_state);
      accept_q  <= is_cn && (state_d == nsl_pkg::preop_one_state);
      cyclic_q  <= (state_d == nsl_pkg::preop_two_state);
    end
  end

  nsl_led_pattern #(
    .FLICKER_HALF_CYC (FLICKER_HALF_CYC),
    .FLASH_ON_CYC     (FLASH_ON_CYC),
    .FLASH_PERIOD_CYC (FLASH_PERIOD_CYC)
  ) u_green (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .clk_en_i   (clk_en_i),
    .restart_i  (state_change),
    .mode_i     (led_mode),
    .led_o      (led_green_o)
  );

  assign state_o         = state_q;
  assign led_red_o       = red_q;
  assign mn_halted_o     = halted_q;
  assign tcp_ip_mode_o   = tcp_q;
  assign reduced_cycle_o = reduced_q;
  assign accept_config_o = accept_q;
  assign cyclic_enable_o = cyclic_q;

  chk_green_off_inactive: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    in_inactive |-> !led_green_o)
    else $error("green LED lit while inactive");

  chk_mn_timeout_preop: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    clk_en_i && !iface_reset_i && is_mn && watching && !proto_frame_i && tmo_expired
    |=> state_q == nsl_pkg::preop_one_state)
    else $error("managing node missed preop one after timeout");

  chk_mn_not_started: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    clk_en_i && !iface_reset_i && is_mn && watching && proto_frame_i
    |=> halted_q && in_inactive ##1 (in_inactive || !$past(clk_en_i) || $past(iface_reset_i)))
    else $error("managing node started despite foreign traffic");

  chk_cn_timeout_plain: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    clk_en_i && !iface_reset_i && is_cn && watching && !proto_frame_i && tmo_expired
    |=> in_plain ##1 (!led_green_o || in_plain))
    else $error("controlled node missed plain ethernet after timeout");

  chk_cn_frame_preop: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    clk_en_i && !iface_reset_i && is_cn && watching && proto_frame_i
    |=> in_preop1 && accept_config_o)
    else $error("controlled node ignored frame in inactive state");

  chk_tcp_mode_flag: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    tcp_ip_mode_o |-> in_plain && !cyclic_enable_o)
    else $error("tcp mode flag out of step with state");

  chk_mn_plain_holds: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    in_plain && is_mn && !iface_reset_i |=> in_plain || $past(!managing_node_i))
    else $error("managing node left plain ethernet without reset");

  chk_cn_plain_exit: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    clk_en_i && in_plain && is_cn && proto_frame_i && !iface_reset_i
    |=> in_preop1 ##1 !tcp_ip_mode_o || !clk_en_i)
    else $error("controlled node stayed in plain ethernet on frame");

  chk_mn_reduced: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    clk_en_i && is_mn && state_d == nsl_pkg::preop_one_state
    |=> reduced_cycle_o && !cyclic_enable_o)
    else $error("managing node preop one without reduced cycle");

  chk_cn_soc_preop2: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    clk_en_i && in_preop1 && is_cn && soc_frame_i && !iface_reset_i
    |=> in_preop2 && cyclic_enable_o && !accept_config_o)
    else $error("start of cycle did not reach preop two");

  chk_red_mn_failed: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    clk_en_i && is_cn && in_preop1 && mn_failed_i && !soc_frame_i && !iface_reset_i
    |=> led_red_o)
    else $error("red LED dark with failed managing node");

  chk_timeout_restart: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    clk_en_i && iface_reset_i |=> tmo_cnt_q == '0 && in_inactive && !halted_q)
    else $error("timeout counter not restarted by interface reset");

  chk_flash_first_on: assert property (
    @(posedge core_clk_i) disable iff (!reset_n_i)
    clk_en_i && in_inactive && state_d == nsl_pkg::preop_one_state
    |=> led_green_o)
    else $error("single flash did not open with the LED lit");

endmodule : nsl_node_state

// >>> tb/nsl_bus_model.sv
// stand-in for the other nodes on the fieldbus segment
// assumes one 250 MHz core clock; pulses are one cycle wide, driven after a rising edge
`timescale 1ns/1ps
module nsl_bus_model (
  input  wire logic core_clk_i,
  output logic      proto_frame_o,
  output logic      soc_frame_o,
  output logic      mn_failed_o
);
  initial begin
    proto_frame_o = 1'b0;
    soc_frame_o   = 1'b0;
    mn_failed_o   = 1'b0;
  end

  task automatic send_proto();
    @(posedge core_clk_i);
    proto_frame_o <= 1'b1;
    @(posedge core_clk_i);
    proto_frame_o <= 1'b0;
  endtask : send_proto

  // the managing node must open each cycle with this frame
  task automatic send_soc();
    @(posedge core_clk_i);
    soc_frame_o <= 1'b1;
    @(posedge core_clk_i);
    soc_frame_o <= 1'b0;
  endtask : send_soc

  task automatic set_failed(input logic v);
    @(posedge core_clk_i);
    mn_failed_o <= v;
  endtask : set_failed
endmodule : nsl_bus_model

// >>> tb/tb_nsl_node_state.sv
// self-checking bench for the node-state sequencer and its status LEDs
// assumes shortened LED prescalers (4/2/8 cycles) so patterns fit a short run
`timescale 1ns/1ps
module tb_nsl_node_state;
  localparam int unsigned HALF = 4;
  localparam int unsigned ON   = 2;
  localparam int unsigned PER  = 8;
  logic                          core_clk_i = 1'b0;
  logic                          reset_n_i = 1'b0;
  logic                          clk_en_i = 1'b1;
  logic                          iface_reset_i = 1'b0;
  logic                          managing_node_i = 1'b0;
  logic [nsl_pkg::TIMEOUT_W-1:0] timeout_cycles_i = 32'h0000_0003;
  logic                          proto_frame_i;
  logic                          soc_frame_i;
  logic                          mn_failed_i;
  logic [1:0]                    state_o;
  logic                          led_green_o, led_red_o, mn_halted_o, tcp_ip_mode_o;
  logic                          reduced_cycle_o, accept_config_o, cyclic_enable_o;
  int                            n_fail = 0;
  int                            tests_run = 0;

  always #2 core_clk_i = ~core_clk_i;

  nsl_bus_model i_nsl_bus_model (.core_clk_i(core_clk_i), .proto_frame_o(proto_frame_i),
    .soc_frame_o(soc_frame_i), .mn_failed_o(mn_failed_i));

  nsl_node_state #(.FLICKER_HALF_CYC(HALF), .FLASH_ON_CYC(ON), .FLASH_PERIOD_CYC(PER))
  i_nsl_node_state (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .iface_reset_i(iface_reset_i), .managing_node_i(managing_node_i),
    .timeout_cycles_i(timeout_cycles_i), .proto_frame_i(proto_frame_i),
    .soc_frame_i(soc_frame_i), .mn_failed_i(mn_failed_i), .state_o(state_o),
    .led_green_o(led_green_o), .led_red_o(led_red_o), .mn_halted_o(mn_halted_o),
    .tcp_ip_mode_o(tcp_ip_mode_o), .reduced_cycle_o(reduced_cycle_o),
    .accept_config_o(accept_config_o), .cyclic_enable_o(cyclic_enable_o));

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic [1:0] got, input logic [1:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask : chk

  // restarts the interface in the given role; timeout counter begins afresh
  task automatic restart(input logic mn);
    @(posedge core_clk_i);
    iface_reset_i   <= 1'b1;
    managing_node_i <= mn;
    @(posedge core_clk_i);
    iface_reset_i <= 1'b0;
    @(negedge core_clk_i);
    chk(state_o, 2'h0, "state after restart");
    chk(led_green_o, 1'b0, "green in inactive");
  endtask : restart

  // bounded wait; returns at the first settled cycle of the new state
  task automatic wait_state(input logic [1:0] s);
    int i;
    for (i = 0; i < 40 && state_o !== s; i++) @(negedge core_clk_i);
    if (state_o !== s) begin
      n_fail++;
      $display("mismatch at %0t: state %0h never reached", $time, s);
      results();
    end
  endtask : wait_state

  task automatic pattern(input int unsigned lit, input int unsigned len, input string what);
    int i;
    for (i = 0; i < len; i++) begin
      chk(led_green_o, (i % PER) < lit, what);
      @(negedge core_clk_i);
    end
  endtask : pattern

  task automatic cn_path();
    restart(1'b0);
    chk(state_o, 2'h0, "cn still watching");
    wait_state(2'h1);
    chk(tcp_ip_mode_o, 1'b1, "tcp mode in plain");
    pattern(HALF, 2 * HALF, "flicker");
    i_nsl_bus_model.set_failed(1'b1);
    i_nsl_bus_model.send_proto();
    wait_state(2'h2);
    chk(accept_config_o, 1'b1, "accept config");
    chk(tcp_ip_mode_o, 1'b0, "tcp mode off");
    chk(led_red_o, 1'b1, "red for failed mn");
    pattern(ON, PER + ON, "flash cn");
    i_nsl_bus_model.send_soc();
    wait_state(2'h3);
    chk(cyclic_enable_o, 1'b1, "cyclic in preop two");
    chk(accept_config_o, 1'b0, "accept dropped");
    i_nsl_bus_model.set_failed(1'b0);
    $display("test cn_path done");
  endtask : cn_path

  task automatic cn_early();
    restart(1'b0);
    i_nsl_bus_model.send_proto();
    @(negedge core_clk_i);
    chk(state_o, 2'h2, "cn frame before timeout");
    $display("test cn_early done");
  endtask : cn_early

  task automatic mn_timeout();
    i_nsl_bus_model.set_failed(1'b1);
    restart(1'b1);
    wait_state(2'h2);
    chk(reduced_cycle_o, 1'b1, "reduced cycle");
    chk(cyclic_enable_o, 1'b0, "no cyclic in preop one");
    chk(led_red_o, 1'b0, "red only for cn");
    pattern(ON, PER + ON, "flash mn");
    i_nsl_bus_model.send_soc();
    i_nsl_bus_model.send_proto();
    @(negedge core_clk_i);
    chk(state_o, 2'h2, "mn ignores frames in preop one");
    i_nsl_bus_model.set_failed(1'b0);
    $display("test mn_timeout done");
  endtask : mn_timeout

  task automatic mn_halt();
    restart(1'b1);
    i_nsl_bus_model.send_proto();
    repeat (10) @(negedge core_clk_i);
    chk(mn_halted_o, 1'b1, "mn refused start");
    chk(state_o, 2'h0, "mn stays inactive");
    chk(led_green_o, 1'b0, "green off while halted");
    restart(1'b1);
    chk(mn_halted_o, 1'b0, "halt cleared by restart");
    $display("test mn_halt done");
  endtask : mn_halt

  task automatic freeze_hold();
    restart(1'b0);
    @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    repeat (10) @(negedge core_clk_i);
    chk(state_o, 2'h0, "frozen while enable low");
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    wait_state(2'h1);
    $display("test freeze_hold done");
  endtask : freeze_hold

  initial begin
    repeat (8) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    cn_path();
    cn_early();
    mn_timeout();
    mn_halt();
    freeze_hold();
    results();
  end
endmodule : tb_nsl_node_state
